// File: rtl/cycle_req_consts.vh
// Timing and threshold constants for the secondary cycle request control
`ifndef CYCLE_REQ_CONSTS_VH
`define CYCLE_REQ_CONSTS_VH

// Core clock
`define CLK_FREQ_HZ          32'h0131_2D00
`define CLK_FREQ_MHZ         32'h0000_0014

// Oscillator: average slot rate, jitter peak-to-peak, jitter sweep rate
`define OSC_NOM_FREQ_HZ      32'h0001_86A0
`define OSC_JITTER_PP_HZ     32'h0000_1770
`define OSC_SWEEP_FREQ_HZ    32'h0000_03E8

// Short comparator deglitch, must stay under 10 us
`define FB_SHORT_DEGLITCH_NS 32'h0000_1388
// Undervoltage qualifying time and request skip time
`define UV_QUALIFY_US        32'h0000_03E8
`define REQ_SKIP_US          32'h0000_7530

// Handshake supervision: consecutive miss or unrequested slots
`define LINK_FAULT_SLOTS     32'h0000_0006

// Current limit state selection from recent slot history
`define ILIM_HIST_LEN        32'h0000_0008
`define ILIM_TH_TOP          32'h0000_0007
`define ILIM_TH_HIGH         32'h0000_0005
`define ILIM_TH_MID          32'h0000_0003
`define ILIM_RESET_STATE     2'h3

`endif

// File: rtl/pin_sync3.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 #(
    parameter WIDTH = 1
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_q
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    genvar i;

    always @(posedge core_clk) begin
        if (rst) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change is taken only once the last two stages agree
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge core_clk) begin
                if (rst) begin
                    pin_q[i] <= 1'b0;
                end else if (s2_r[i] == s3_r[i]) begin
                    pin_q[i] <= s3_r[i];
                end
            end
        end
    endgenerate
endmodule // pin_sync3

// File: rtl/jitter_osc.v
// Jittered slot oscillator, one-cycle pulse per period
`timescale 1ns/1ps
`include "cycle_req_consts.vh"
module jitter_osc #(
    parameter CNT_W  = 8,
    parameter STEP_W = 10
) (
    input  wire core_clk,
    input  wire rst,
    output reg  slot_start
);
    localparam integer BASE = `CLK_FREQ_HZ / `OSC_NOM_FREQ_HZ;
    localparam integer DEV  =
        `CLK_FREQ_HZ / (`OSC_NOM_FREQ_HZ - `OSC_JITTER_PP_HZ / 2) - BASE;
    localparam integer STEP = `CLK_FREQ_HZ / `OSC_SWEEP_FREQ_HZ / (4 * DEV);
    localparam integer LO   = BASE - DEV;
    localparam integer SPAN = 2 * DEV;

    wire [31:0]       lo_w    = LO;
    wire [31:0]       span_w  = SPAN;
    wire [31:0]       step_w  = STEP - 1;
    reg  [CNT_W-1:0]  cnt_r;
    reg  [CNT_W-1:0]  offset_r;
    reg               up_r;
    reg  [STEP_W-1:0] step_r;
    wire [CNT_W-1:0]  period = lo_w[CNT_W-1:0] + offset_r;

    // Triangle sweep of the period, independent of slot edges
    always @(posedge core_clk) begin
        if (rst) begin
            step_r   <= {STEP_W{1'b0}};
            offset_r <= span_w[CNT_W:1];
            up_r     <= 1'b1;
        end else if (step_r == step_w[STEP_W-1:0]) begin
            step_r <= {STEP_W{1'b0}};
            if (up_r) begin
                offset_r <= offset_r + 1'b1;
                if (offset_r == span_w[CNT_W-1:0] - 1'b1)
                    up_r <= 1'b0;
            end else begin
                offset_r <= offset_r - 1'b1;
                if (offset_r == {{(CNT_W-1){1'b0}}, 1'b1})
                    up_r <= 1'b1;
            end
        end else begin
            step_r <= step_r + 1'b1;
        end
    end

    // Free-running, never gated by the control state
    always @(posedge core_clk) begin
        if (rst) begin
            cnt_r      <= {CNT_W{1'b0}};
            slot_start <= 1'b0;
        end else if (cnt_r >= period - 1'b1) begin
            cnt_r      <= {CNT_W{1'b0}};
            slot_start <= 1'b1;
        end else begin
            cnt_r      <= cnt_r + 1'b1;
            slot_start <= 1'b0;
        end
    end
endmodule // jitter_osc

// File: rtl/cycle_req_ctrl.v
// Secondary-side cycle request, overshoot bleed, fault and sync rectifier control
`timescale 1ns/1ps
`include "cycle_req_consts.vh"
module cycle_req_ctrl #(
    parameter UV_QUALIFY_CYC = `UV_QUALIFY_US * `CLK_FREQ_MHZ,
    parameter REQ_SKIP_CYC   = `REQ_SKIP_US * `CLK_FREQ_MHZ,
    parameter TMR_W          = 24
) (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       fb_below_reg,
    input  wire       fb_over_2pct,
    input  wire       fb_over_20pct,
    input  wire       fb_below_short,
    input  wire       fb_below_undervolt,
    input  wire       current_sense_input_over_3x,
    input  wire       current_sense_input_over_nom,
    input  wire       fwd_pin,
    input  wire       sr_vds_low,
    output reg        cycle_request,
    output reg        bleed_low_en,
    output reg        bleed_high_en,
    output reg        sync_rect_drive,
    output reg        in_control,
    output reg        handshake_active,
    output reg  [1:0] ilim_state
);
    // Control state: who decides the switching cycles
    localparam [1:0] ST_HANDSHAKE = 2'h0;
    localparam [1:0] ST_CONTROL   = 2'h1;
    localparam [1:0] ST_SKIP      = 2'h2;
    localparam [1:0] ST_RELEASED  = 2'h3;

    // Longest time, rounded down
    localparam integer DEGLITCH_CYC = `FB_SHORT_DEGLITCH_NS * `CLK_FREQ_MHZ / 1000;
    localparam integer HIST_LEN     = `ILIM_HIST_LEN;

    wire [31:0] degl_w  = DEGLITCH_CYC - 1;
    wire [31:0] uv_w    = UV_QUALIFY_CYC - 1;
    wire [31:0] skip_w  = REQ_SKIP_CYC - 1;
    wire [31:0] fault_w = `LINK_FAULT_SLOTS;
    wire [31:0] th_top  = `ILIM_TH_TOP;
    wire [31:0] th_high = `ILIM_TH_HIGH;
    wire [31:0] th_mid  = `ILIM_TH_MID;

    wire [8:0] pins_q;
    wire       slot_start;

    pin_sync3 #(
        .WIDTH   (9)
    ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin_in   ({sr_vds_low, fwd_pin, current_sense_input_over_nom, current_sense_input_over_3x,
                    fb_below_undervolt, fb_below_short, fb_over_20pct,
                    fb_over_2pct, fb_below_reg}),
        .pin_q    (pins_q)
    );

    jitter_osc u_osc (
        .core_clk   (core_clk),
        .rst        (rst),
        .slot_start (slot_start)
    );

    wire fb_low   = pins_q[0];
    wire ovs_low  = pins_q[1];
    wire ovs_high = pins_q[2];
    wire short_in = pins_q[3];
    wire uv_in    = pins_q[4];
    wire surge_in = pins_q[5];
    wire nom_in   = pins_q[6];
    wire fwd_q    = pins_q[7];
    wire vds_low  = pins_q[8];

    reg  [1:0]          state_r;
    reg  [1:0]          state_nxt;
    reg                 fwd_d_r;
    reg                 first_hs_r;
    reg                 req_slot_r;
    reg                 sw_seen_r;
    reg  [2:0]          miss_cnt_r;
    reg  [2:0]          unreq_cnt_r;
    reg  [7:0]          degl_cnt_r;
    reg                 short_q_r;
    reg  [TMR_W-1:0]    uv_cnt_r;
    reg  [TMR_W-1:0]    skip_cnt_r;
    reg                 sr_block_r;
    reg  [HIST_LEN-1:0] hist_r;
    reg  [3:0]          ones;
    integer             k;

    wire fwd_rise  = fwd_q & ~fwd_d_r;
    wire fwd_fall  = ~fwd_q & fwd_d_r;
    wire bleeding  = ovs_low | ovs_high;
    wire uv_done   = (uv_cnt_r == uv_w[TMR_W-1:0]);
    wire skip_done = (skip_cnt_r == skip_w[TMR_W-1:0]);
    // Slot decision: feedback below regulation and no short asserted
    wire want_req  = fb_low & ~short_q_r;
    // Handshake requests every slot so the primary can lock onto the pattern
    wire issue_req = slot_start & ((state_r == ST_HANDSHAKE) |
                     ((state_r == ST_CONTROL) & want_req));
    // Outcome of the slot that is closing at this slot start
    wire miss_now  = req_slot_r & ~sw_seen_r;
    wire unreq_now = ~req_slot_r & sw_seen_r;

    always @(posedge core_clk) begin
        if (rst)
            fwd_d_r <= 1'b0;
        else
            fwd_d_r <= fwd_q;
    end

    // Short comparator deglitch; a glitch shorter than the window is dropped
    always @(posedge core_clk) begin
        if (rst) begin
            degl_cnt_r <= 8'h00;
            short_q_r  <= 1'b0;
        end else if (!short_in) begin
            degl_cnt_r <= 8'h00;
            short_q_r  <= 1'b0;
        end else if (degl_cnt_r == degl_w[7:0]) begin
            short_q_r <= 1'b1;
        end else begin
            degl_cnt_r <= degl_cnt_r + 1'b1;
        end
    end

    // Undervoltage qualify timer, only counts while in control
    always @(posedge core_clk) begin
        if (rst || !uv_in || state_r != ST_CONTROL)
            uv_cnt_r <= {TMR_W{1'b0}};
        else if (!uv_done)
            uv_cnt_r <= uv_cnt_r + 1'b1;
    end

    always @(posedge core_clk) begin
        if (rst || state_r != ST_SKIP)
            skip_cnt_r <= {TMR_W{1'b0}};
        else if (!skip_done)
            skip_cnt_r <= skip_cnt_r + 1'b1;
    end

    // Per-slot bookkeeping of requests and primary responses
    always @(posedge core_clk) begin
        if (rst) begin
            req_slot_r  <= 1'b0;
            sw_seen_r   <= 1'b0;
            miss_cnt_r  <= 3'h0;
            unreq_cnt_r <= 3'h0;
        end else if (slot_start) begin
            req_slot_r <= issue_req;
            sw_seen_r  <= 1'b0;
            if (state_r != ST_CONTROL || !miss_now)
                miss_cnt_r <= 3'h0;
            else
                miss_cnt_r <= miss_cnt_r + 1'b1;
            if (state_r != ST_CONTROL || !unreq_now)
                unreq_cnt_r <= 3'h0;
            else
                unreq_cnt_r <= unreq_cnt_r + 1'b1;
        end else if (fwd_rise) begin
            sw_seen_r <= 1'b1;
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_HANDSHAKE: begin
                // Primary answered a handshake request
                if (slot_start && req_slot_r && sw_seen_r) begin
                    if (first_hs_r && short_in)
                        state_nxt = ST_SKIP;
                    else
                        state_nxt = ST_CONTROL;
                end
            end
            ST_CONTROL: begin
                if (short_q_r)
                    state_nxt = ST_RELEASED;
                else if (uv_done && !bleeding)
                    state_nxt = ST_RELEASED;
                else if (slot_start &&
                         ((miss_now && miss_cnt_r == fault_w[2:0] - 1'b1) ||
                          (unreq_now && unreq_cnt_r == fault_w[2:0] - 1'b1)))
                    state_nxt = ST_HANDSHAKE;
            end
            ST_SKIP: begin
                if (skip_done)
                    state_nxt = ST_RELEASED;
            end
            default: begin
                // Primary restarts on its own; take over once it switches again
                if (fwd_rise && !short_q_r)
                    state_nxt = ST_HANDSHAKE;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            state_r    <= ST_HANDSHAKE;
            first_hs_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            // Only the first handshake after reset may divert into the skip
            if (state_r == ST_HANDSHAKE && state_nxt != ST_HANDSHAKE)
                first_hs_r <= 1'b0;
        end
    end

    // Current limit: count enabled slots in the recent history
    always @* begin
        ones = 4'h0;
        for (k = 0; k < HIST_LEN; k = k + 1)
            ones = ones + {3'h0, hist_r[k]};
    end

    always @(posedge core_clk) begin
        if (rst) begin
            hist_r     <= {HIST_LEN{1'b1}};
            ilim_state <= `ILIM_RESET_STATE;
        end else if (slot_start) begin
            hist_r <= {hist_r[HIST_LEN-2:0], issue_req};
            if (ones >= th_top[3:0])
                ilim_state <= 2'h3;
            else if (ones >= th_high[3:0])
                ilim_state <= 2'h2;
            else if (ones >= th_mid[3:0])
                ilim_state <= 2'h1;
            else
                ilim_state <= 2'h0;
        end
    end

    // Overshoot bleed levels; high level implies the low one is superseded
    always @(posedge core_clk) begin
        if (rst) begin
            bleed_low_en  <= 1'b0;
            bleed_high_en <= 1'b0;
        end else begin
            bleed_low_en  <= ovs_low & ~ovs_high;
            bleed_high_en <= ovs_high;
        end
    end

    // Surge blocking holds until current falls back below nominal
    always @(posedge core_clk) begin
        if (rst)
            sr_block_r <= 1'b0;
        else if (surge_in)
            sr_block_r <= 1'b1;
        else if (!nom_in)
            sr_block_r <= 1'b0;
    end

    // Rectifier drive; off edges win over the on edge to avoid overlap
    always @(posedge core_clk) begin
        if (rst)
            sync_rect_drive <= 1'b0;
        else if (issue_req)
            sync_rect_drive <= 1'b0;
        else if (sr_block_r || surge_in || vds_low || state_r != ST_CONTROL)
            sync_rect_drive <= 1'b0;
        else if (fwd_fall && req_slot_r)
            sync_rect_drive <= 1'b1;
    end

    always @(posedge core_clk) begin
        if (rst) begin
            cycle_request    <= 1'b0;
            in_control       <= 1'b0;
            handshake_active <= 1'b0;
        end else begin
            // Registered copies keep every top-level output glitch-free
            cycle_request    <= issue_req;
            in_control       <= (state_r == ST_CONTROL);
            handshake_active <= (state_r == ST_HANDSHAKE);
        end
    end
endmodule // cycle_req_ctrl

// File: verification/cycle_req_ctrl_props.sv
// Port-level assertions for the cycle request controller
`timescale 1ns/1ps
module cycle_req_ctrl_props #(
    parameter UV_QUALIFY_CYC = 20000,
    parameter REQ_SKIP_CYC   = 600000,
    parameter TMR_W          = 24
) (
    input wire       core_clk,
    input wire       rst,
    input wire       fb_below_reg,
    input wire       fb_over_2pct,
    input wire       fb_over_20pct,
    input wire       fb_below_short,
    input wire       fb_below_undervolt,
    input wire       current_sense_input_over_3x,
    input wire       current_sense_input_over_nom,
    input wire       fwd_pin,
    input wire       sr_vds_low,
    input wire       cycle_request,
    input wire       bleed_low_en,
    input wire       bleed_high_en,
    input wire       sync_rect_drive,
    input wire       in_control,
    input wire       handshake_active,
    input wire [1:0] ilim_state
);
    localparam int UV_LIM = UV_QUALIFY_CYC + 8;
    logic [7:0]  gap_r;
    logic        seen_r;
    logic [7:0]  short_r;
    logic [31:0] uv_r;
    wire         bleed = bleed_low_en || bleed_high_en;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Side counters keep long spans out of the property engine; gap_r and short_r saturate, uv_r does not
    always @(posedge core_clk) begin
        if (rst) begin
            gap_r   <= 8'h00;
            seen_r  <= 1'b0;
            short_r <= 8'h00;
            uv_r    <= 32'h0000_0000;
        end else begin
            gap_r   <= cycle_request ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
            seen_r  <= seen_r || cycle_request;
            short_r <= !fb_below_short ? 8'h00 : short_r + {7'h00, short_r != 8'hFF};
            uv_r    <= (!fb_below_undervolt || bleed || !in_control) ? 32'h0000_0000
                                                                     : uv_r + 32'h0000_0001;
        end
    end

    property p_one_pulse; cycle_request |=> !cycle_request; endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("request pulse wider than one cycle");
    property p_slot_min; cycle_request && seen_r |-> gap_r >= 8'hC1; endproperty
    a_slot_min: assert property (p_slot_min)
        else $error("slots closer than the jitter allows");
    property p_no_req_off;
        cycle_request |-> in_control || handshake_active || $past(in_control || handshake_active);
    endproperty
    a_no_req_off: assert property (p_no_req_off)
        else $error("request issued while released");
    property p_sr_rise; $rose(sync_rect_drive) |-> in_control && !$past(fwd_pin, 2); endproperty
    a_sr_rise: assert property (p_sr_rise)
        else $error("rectifier drive without winding fall in control");
    property p_sr_req; cycle_request |-> !sync_rect_drive; endproperty
    a_sr_req: assert property (p_sr_req)
        else $error("rectifier drive overlaps request");
    property p_sr_surge;
        sync_rect_drive |-> !($past(current_sense_input_over_3x, 6) && $past(current_sense_input_over_3x, 7));
    endproperty
    a_sr_surge: assert property (p_sr_surge)
        else $error("rectifier drive during current surge");
    property p_short; short_r > 8'h6E |-> !in_control; endproperty
    a_short: assert property (p_short)
        else $error("control kept with feedback shorted");
    property p_uv; uv_r > UV_LIM |-> !in_control; endproperty
    a_uv: assert property (p_uv)
        else $error("control kept past undervolt qualify time");
    property p_bleed_low; (fb_over_2pct && !fb_over_20pct) [*8] |-> bleed_low_en; endproperty
    a_bleed_low: assert property (p_bleed_low)
        else $error("low discharge sink missing");
    property p_bleed_high; fb_over_20pct [*8] |-> bleed_high_en && !bleed_low_en; endproperty
    a_bleed_high: assert property (p_bleed_high)
        else $error("high discharge sink missing");

    c_ctl_req: cover property (in_control && cycle_request);
    c_sr_on: cover property ($rose(sync_rect_drive));
    c_high: cover property ($rose(bleed_high_en));
endmodule // cycle_req_ctrl_props

bind cycle_req_ctrl cycle_req_ctrl_props #(
    .UV_QUALIFY_CYC(UV_QUALIFY_CYC), .REQ_SKIP_CYC(REQ_SKIP_CYC), .TMR_W(TMR_W)
) u_props (
    .core_clk(core_clk), .rst(rst), .fb_below_reg(fb_below_reg),
    .fb_over_2pct(fb_over_2pct), .fb_over_20pct(fb_over_20pct),
    .fb_below_short(fb_below_short), .fb_below_undervolt(fb_below_undervolt),
    .current_sense_input_over_3x(current_sense_input_over_3x), .current_sense_input_over_nom(current_sense_input_over_nom),
    .fwd_pin(fwd_pin), .sr_vds_low(sr_vds_low), .cycle_request(cycle_request),
    .bleed_low_en(bleed_low_en), .bleed_high_en(bleed_high_en),
    .sync_rect_drive(sync_rect_drive), .in_control(in_control),
    .handshake_active(handshake_active), .ilim_state(ilim_state)
);

// File: verification/primary_switch_model.sv
// Behavioural primary-side switch answering requests on the winding sense line
`timescale 1ns/1ps
module primary_switch_model (
    input  wire       core_clk,
    input  wire       cycle_request,
    input  wire [1:0] mode,
    output logic      fwd_pin
);
    // Modes: 0 prompt, 1 slow, 2 mute, 3 free-running without requests
    int         cnt = 0;
    int         free = 0;
    logic [1:0] mode_q = 2'h0;
    initial fwd_pin = 1'b0;
    // Mode is taken on the rising edge so a change made at the falling edge cannot race
    always @(posedge core_clk) begin
        mode_q <= mode;
    end
    always @(negedge core_clk) begin
        free <= (free >= 199) ? 0 : free + 1;
        // A started cycle always runs out; requests meanwhile are ignored
        if (cnt != 0) begin
            cnt <= cnt - 1;
        end else if ((cycle_request && mode_q < 2'h2) || (mode_q == 2'h3 && free == 0)) begin
            cnt <= (mode_q == 2'h1) ? 80 : 24;
        end
        fwd_pin <= (cnt != 0) && (cnt <= ((mode_q == 2'h1) ? 40 : 20));
    end
endmodule // primary_switch_model

// File: verification/secondary_cycle_request_control_tb_top.sv
// Self-checking bench for the cycle request controller
`timescale 1ns/1ps
module secondary_cycle_request_control_tb_top;
    localparam int UVQ = 50;
    localparam int SKP = 100;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        fb_below_reg = 1'b0;
    logic        fb_over_2pct = 1'b0;
    logic        fb_over_20pct = 1'b0;
    logic        fb_below_short = 1'b0;
    logic        fb_below_undervolt = 1'b0;
    logic        current_sense_input_over_3x = 1'b0;
    logic        current_sense_input_over_nom = 1'b0;
    logic        fwd_pin;
    logic [1:0]  mode = 2'h0;
    logic        cycle_request, bleed_low_en, bleed_high_en, sync_rect_drive;
    logic        in_control, handshake_active;
    logic [1:0]  ilim_state;
    logic [31:0] seed = 32'h0000_1456;
    logic [7:0]  mask;
    int          n, mismatches = 0, n_tests = 0;

    always #25 core_clk = ~core_clk;

    cycle_req_ctrl #(.UV_QUALIFY_CYC(UVQ), .REQ_SKIP_CYC(SKP), .TMR_W(24)) uut (
        .core_clk(core_clk), .rst(rst), .fb_below_reg(fb_below_reg),
        .fb_over_2pct(fb_over_2pct), .fb_over_20pct(fb_over_20pct),
        .fb_below_short(fb_below_short), .fb_below_undervolt(fb_below_undervolt),
        .current_sense_input_over_3x(current_sense_input_over_3x), .current_sense_input_over_nom(current_sense_input_over_nom),
        .fwd_pin(fwd_pin), .sr_vds_low(1'b0), .cycle_request(cycle_request),
        .bleed_low_en(bleed_low_en), .bleed_high_en(bleed_high_en),
        .sync_rect_drive(sync_rect_drive), .in_control(in_control),
        .handshake_active(handshake_active), .ilim_state(ilim_state));
    primary_switch_model u_pri (.core_clk(core_clk), .cycle_request(cycle_request),
        .mode(mode), .fwd_pin(fwd_pin));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] exp_ilim(input logic [7:0] m);
        int c;
        c = $countones(m);
        return (c >= 7) ? 8'h03 : (c >= 5) ? 8'h02 : (c >= 3) ? 8'h01 : 8'h00;
    endfunction
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Select 0 control, 1 handshake, 2 request pulse
    task automatic wait_on(input int sel, input logic val, input int lim);
        logic s;
        for (int i = 0; i <= lim; i++) begin
            cyc(1);
            s = (sel == 0) ? in_control : (sel == 1) ? handshake_active : cycle_request;
            if (s === val) return;
        end
        mismatches++;
        wrap_up();
    endtask
    task automatic count_req(input int k);
        n = 0;
        repeat (k) begin
            cyc(1);
            if (cycle_request === 1'b1) n++;
        end
    endtask
    // Free switching wakes a released secondary, then answers bring it back
    task automatic regain;
        mode = 2'h3;
        wait_on(1, 1'b1, 800);
        mode = 2'h0;
        wait_on(0, 1'b1, 3000);
    endtask

    initial begin
        cyc(16);
        rst = 1'b0;
        cyc(1);
        chk({6'h00, ilim_state}, 8'h03);
        chk({7'h00, handshake_active}, 8'h01);
        fb_below_reg = 1'b1;
        wait_on(0, 1'b1, 3000);
        for (int t = 0; t < 7; t++) begin
            seed = xs(seed);
            mask = (t == 0) ? 8'hFF : (t == 1) ? 8'h00 : (t == 2) ? 8'h1F : seed[7:0];
            fb_below_reg = 1'b1;
            wait_on(2, 1'b1, 400);
            cyc(100);
            for (int i = 0; i < 8; i++) begin
                fb_below_reg = mask[i];
                cyc(200);
            end
            fb_below_reg = 1'b0;
            cyc(200);
            chk({6'h00, ilim_state}, exp_ilim(mask));
        end
        fb_below_reg = 1'b1;
        mode = 2'h1;
        wait_on(2, 1'b1, 400);
        cyc(100);
        chk({7'h00, sync_rect_drive}, 8'h01);
        wait_on(2, 1'b1, 400);
        chk({7'h00, sync_rect_drive}, 8'h00);
        mode = 2'h0;
        current_sense_input_over_3x = 1'b1;
        current_sense_input_over_nom = 1'b1;
        cyc(10);
        current_sense_input_over_3x = 1'b0;
        wait_on(2, 1'b1, 400);
        cyc(45);
        chk({7'h00, sync_rect_drive}, 8'h00);
        current_sense_input_over_nom = 1'b0;
        wait_on(2, 1'b1, 400);
        cyc(45);
        chk({7'h00, sync_rect_drive}, 8'h01);
        fb_over_2pct = 1'b1;
        cyc(12);
        chk({6'h00, bleed_high_en, bleed_low_en}, 8'h01);
        fb_over_20pct = 1'b1;
        cyc(12);
        chk({6'h00, bleed_high_en, bleed_low_en}, 8'h02);
        fb_below_undervolt = 1'b1;
        cyc(UVQ + 60);
        chk({7'h00, in_control}, 8'h01);
        fb_over_2pct = 1'b0;
        fb_over_20pct = 1'b0;
        cyc(20);
        chk({7'h00, in_control}, 8'h00);
        fb_below_undervolt = 1'b0;
        regain();
        repeat (3) begin
            fb_below_undervolt = 1'b1;
            cyc(UVQ - 15);
            fb_below_undervolt = 1'b0;
            cyc(10);
        end
        chk({7'h00, in_control}, 8'h01);
        wait_on(2, 1'b1, 400);
        cyc(40);
        mode = 2'h2;
        n = 0;
        for (int i = 0; i < 2000 && handshake_active !== 1'b1; i++) begin
            cyc(1);
            if (cycle_request === 1'b1 && in_control === 1'b1) n++;
        end
        // Six unanswered requests; the slot that restarts the handshake still requests
        chk(n[7:0], 8'h07);
        mode = 2'h0;
        wait_on(0, 1'b1, 3000);
        fb_below_reg = 1'b0;
        mode = 2'h3;
        wait_on(1, 1'b1, 3000);
        mode = 2'h0;
        fb_below_reg = 1'b1;
        wait_on(0, 1'b1, 3000);
        fb_below_short = 1'b1;
        cyc(130);
        chk({7'h00, in_control}, 8'h00);
        count_req(400);
        chk(n[7:0], 8'h00);
        rst = 1'b1;
        cyc(16);
        rst = 1'b0;
        wait_on(1, 1'b0, 3000);
        chk({7'h00, in_control}, 8'h00);
        // Span the skip and two later slots, so a wrongly issued request is seen
        count_req(SKP + 400);
        chk(n[7:0], 8'h00);
        wrap_up();
    end
endmodule // secondary_cycle_request_control_tb_top
